//--- logic/bsw_pkg.sv
// package for the battery-backed sram bus master
// assumes a 25 mhz clock driving the host side of the sram pins
// How it works
// - master holds address stable through write
// - master waits address hold before next cycle
// - master keeps output gate high during writes
// - master keeps selects inactive as supply rises
// - interrupt open drain, pull-up needed
package bsw_pkg;
	localparam int ADDR_W        = 13;
	localparam int DATA_W        = 8;
	localparam int CLK_NS        = 40;
	// write strobe pulse width and data setup, nanoseconds
	localparam int T_PULSE_NS    = 100;
	localparam int T_SETUP_NS    = 70;
	localparam int T_HOLD_NS     = 10;
	localparam int T_FLOAT_NS    = 70;
	localparam int T_ACCESS_NS   = 150;
	// recovery time after supply return, microseconds
	localparam int T_REC_US      = 200;
	localparam int PULSE_CYC     = (T_PULSE_NS + CLK_NS - 1) / CLK_NS;
	localparam int HOLD_CYC      = (T_HOLD_NS + CLK_NS - 1) / CLK_NS;
	localparam int FLOAT_CYC     = (T_FLOAT_NS + CLK_NS - 1) / CLK_NS;
	localparam int ACCESS_CYC    = (T_ACCESS_NS + CLK_NS - 1) / CLK_NS;
	localparam int REC_CYC       = (T_REC_US * 1000 + CLK_NS - 1) / CLK_NS;
	localparam int CNT_W         = 16;
	typedef enum logic [2:0] {
		BSW_IDLE  = 3'b000,
		BSW_SETUP = 3'b001,
		BSW_PULSE = 3'b011,
		BSW_HOLD  = 3'b010,
		BSW_READ  = 3'b100,
		BSW_DONE  = 3'b110
	} bsw_state_e;
endpackage

//--- logic/bsw_sync.sv
// three-stage synchroniser with agreement filter
// assumes an asynchronous pin input
module bsw_sync (
	input  wire logic clk,   // clock
	input  wire logic rst,   // sync reset
	input  wire logic ce,    // clock enable
	input  wire logic din,   // async input
	output logic      dout   // filtered level
);
	logic s1_q, s2_q, s3_q, out_q, out_d;
	always_comb begin
		out_d = out_q;
		if (s2_q == s3_q) begin
			out_d = s3_q;
		end
	end
	always_ff @(posedge clk) begin
		if (rst) begin
			s1_q  <= 1'b1;
			s2_q  <= 1'b1;
			s3_q  <= 1'b1;
			out_q <= 1'b1;
		end else if (ce) begin
			s1_q  <= din;
			s2_q  <= s1_q;
			s3_q  <= s2_q;
			out_q <= out_d;
		end
	end
	assign dout = out_q;
endmodule

//--- logic/bsw_host.sv
// host bus master for a battery-backed byte-wide sram
// assumes the bench resolves the data bus and interrupt pull-up
module bsw_host
	import bsw_pkg::*;
#(
	parameter int REC_CYCLES = REC_CYC
) (
	input  wire logic                       clk,         // clock
	input  wire logic                       rst,         // sync reset
	input  wire logic                       ce,          // clock enable
	input  wire logic                       req,         // start access
	input  wire logic                       req_write,   // 1 write, 0 read
	input  wire logic [bsw_pkg::ADDR_W-1:0] req_addr,    // byte address
	input  wire logic [bsw_pkg::DATA_W-1:0] req_wdata,   // write data
	output logic                            busy,        // access running
	output logic                            done,        // access finished
	output logic [bsw_pkg::DATA_W-1:0]      rdata,       // read data
	output logic                            power_fail,  // supply low
	output logic [bsw_pkg::ADDR_W-1:0]      addr,        // address pins
	output logic                            select_low_active_n, // sel
	output logic                            select_high_active,  // sel
	output logic                            write_n,     // write strobe
	output logic                            gate_n,      // output gate
	output logic [bsw_pkg::DATA_W-1:0]      dq_o,        // data out
	output logic                            dq_oe,       // data drive
	input  wire logic [bsw_pkg::DATA_W-1:0] dq_i,        // data in
	input  wire logic                       pfail_int_n  // interrupt pin
);
	import bsw_pkg::*;

	// ==========================================================
	// interrupt pin sync and recovery timer
	logic int_n_s;
	bsw_sync u_sync (
		.clk  (clk),
		.rst  (rst),
		.ce   (ce),
		.din  (pfail_int_n),
		.dout (int_n_s)
	);

	logic [CNT_W-1:0] rec_q, rec_d;
	logic             pf_q, pf_d;
	always_comb begin
		pf_d  = pf_q;
		rec_d = rec_q;
		if (!int_n_s) begin
			pf_d  = 1'b1;
			rec_d = CNT_W'(REC_CYCLES);
		end else if (rec_q != '0) begin
			rec_d = rec_q - CNT_W'(1);
		end else begin
			pf_d = 1'b0;
		end
	end
	always_ff @(posedge clk) begin
		if (rst) begin
			pf_q  <= 1'b0;
			rec_q <= '0;
		end else if (ce) begin
			pf_q  <= pf_d;
			rec_q <= rec_d;
		end
	end

	// ==========================================================
	// access sequencer
	bsw_state_e       st_q, st_d;
	logic [CNT_W-1:0] cnt_q, cnt_d;
	logic [ADDR_W-1:0] a_q, a_d;
	logic [DATA_W-1:0] wd_q, wd_d, rd_q, rd_d;
	logic             wr_q, wr_d, sel_q, sel_d, we_q, we_d;
	logic             g_q, g_d, oe_q, oe_d, done_q, done_d;
	// pin copies so every output leaves a flip-flop
	logic             busy_q, busy_d, seln_q, seln_d, wn_q, wn_d;

	always_comb begin
		st_d   = st_q;
		cnt_d  = cnt_q;
		a_d    = a_q;
		wd_d   = wd_q;
		rd_d   = rd_q;
		wr_d   = wr_q;
		sel_d  = sel_q;
		we_d   = we_q;
		g_d    = g_q;
		oe_d   = oe_q;
		done_d = 1'b0;
		case (st_q)
			BSW_IDLE: begin
				// selects stay off while supply is low
				if (req && !pf_q) begin
					a_d   = req_addr;
					wd_d  = req_wdata;
					wr_d  = req_write;
					sel_d = 1'b1;
					g_d   = 1'b1;
					cnt_d = CNT_W'(FLOAT_CYC);
					st_d  = req_write ? BSW_SETUP : BSW_READ;
					if (!req_write) begin
						g_d   = 1'b0;
						cnt_d = CNT_W'(ACCESS_CYC);
					end
				end
			end
			BSW_SETUP: begin
				// strobe after selects so write starts on it
				we_d  = 1'b1;
				oe_d  = 1'b1;
				cnt_d = CNT_W'(PULSE_CYC);
				st_d  = BSW_PULSE;
			end
			BSW_PULSE: begin
				if (cnt_q > CNT_W'(1)) begin
					cnt_d = cnt_q - CNT_W'(1);
				end else begin
					we_d  = 1'b0;
					cnt_d = CNT_W'(HOLD_CYC);
					st_d  = BSW_HOLD;
				end
			end
			BSW_HOLD: begin
				// data and address held past strobe release
				sel_d = 1'b0;
				oe_d  = 1'b0;
				st_d  = BSW_DONE;
			end
			BSW_READ: begin
				if (cnt_q > CNT_W'(1)) begin
					cnt_d = cnt_q - CNT_W'(1);
				end else begin
					rd_d  = dq_i;
					sel_d = 1'b0;
					g_d   = 1'b1;
					st_d  = BSW_DONE;
				end
			end
			BSW_DONE: begin
				done_d = 1'b1;
				st_d   = BSW_IDLE;
			end
			default: begin
				st_d = BSW_IDLE;
			end
		endcase
		busy_d = (st_d != BSW_IDLE);
		seln_d = ~sel_d;
		wn_d   = ~we_d;
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			st_q   <= BSW_IDLE;
			cnt_q  <= '0;
			a_q    <= '0;
			wd_q   <= '0;
			rd_q   <= '0;
			wr_q   <= 1'b0;
			sel_q  <= 1'b0;
			we_q   <= 1'b0;
			g_q    <= 1'b1;
			oe_q   <= 1'b0;
			done_q <= 1'b0;
			busy_q <= 1'b0;
			seln_q <= 1'b1;
			wn_q   <= 1'b1;
		end else if (ce) begin
			st_q   <= st_d;
			cnt_q  <= cnt_d;
			a_q    <= a_d;
			wd_q   <= wd_d;
			rd_q   <= rd_d;
			wr_q   <= wr_d;
			sel_q  <= sel_d;
			we_q   <= we_d;
			g_q    <= g_d;
			oe_q   <= oe_d;
			done_q <= done_d;
			busy_q <= busy_d;
			seln_q <= seln_d;
			wn_q   <= wn_d;
		end
	end

	assign busy                = busy_q;
	assign done                = done_q;
	assign rdata               = rd_q;
	assign power_fail          = pf_q;
	assign addr                = a_q;
	assign select_low_active_n = seln_q;
	assign select_high_active  = sel_q;
	assign write_n             = wn_q;
	assign gate_n              = g_q;
	assign dq_o                = wd_q;
	assign dq_oe               = oe_q;

	// ==========================================================
	// checks
	sequence strobe_low_s;
		!write_n;
	endsequence
	sequence strobe_rel_s;
		write_n;
	endsequence

	gate_in_write_a: assert property (@(posedge clk) disable iff (rst)
		!write_n |-> gate_n)
		else $error("gate active during write");
	write_frame_a: assert property (@(posedge clk) disable iff (rst)
		!write_n |-> !select_low_active_n && select_high_active && dq_oe)
		else $error("strobe without selects");
	addr_stable_a: assert property (@(posedge clk) disable iff (rst || !ce)
		!write_n |=> $stable(addr) || write_n)
		else $error("address moved in write");
	pulse_width_a: assert property (@(posedge clk) disable iff (rst || !ce)
		$fell(write_n) |-> strobe_low_s [*3] ##1 strobe_rel_s)
		else $error("strobe width wrong");
	hold_sel_a: assert property (@(posedge clk) disable iff (rst || !ce)
		$rose(write_n) |-> !select_low_active_n && dq_oe)
		else $error("no hold after strobe");
	pf_block_a: assert property (@(posedge clk) disable iff (rst || !ce)
		$rose(select_high_active) |-> !$past(pf_q))
		else $error("select during power fail");
	pf_track_a: assert property (@(posedge clk) disable iff (rst || !ce)
		!int_n_s |=> power_fail)
		else $error("power fail not flagged");
	read_gate_a: assert property (@(posedge clk) disable iff (rst)
		!gate_n |-> write_n && !dq_oe && select_high_active)
		else $error("read framing wrong");
	rec_wait_a: assert property (@(posedge clk) disable iff (rst || !ce)
		$rose(int_n_s) |=> power_fail)
		else $error("recovery skipped");
endmodule

//--- verification/bsw_sram_model.sv
// behavioural byte-wide sram with power-fail deselect
// assumes the bench resolves the data bus and pull-up
module bsw_sram_model
	import bsw_pkg::*;
#(
	parameter int DESEL_NS = 15000,
	parameter int REC_NS   = 200
) (
	input  wire logic [bsw_pkg::ADDR_W-1:0] addr,  // address
	input  wire logic                       sel_n, // low select
	input  wire logic                       sel_h, // high select
	input  wire logic                       wr_n,  // strobe
	input  wire logic                       g_n,   // gate
	input  wire logic [bsw_pkg::DATA_W-1:0] dq,    // bus level
	input  wire logic                       low,   // supply low
	output logic [bsw_pkg::DATA_W-1:0]      q,     // read data
	output logic                            q_oe,  // drives bus
	output logic                            int_lo // pulls pin low
);
	logic [DATA_W-1:0] mem [2**ADDR_W];
	logic              desel = 1'b0;
	logic              wr_act;
	// ends on first release; data at that moment stored
	assign wr_act = ~wr_n & ~sel_n & sel_h & ~desel;
	always @(negedge wr_act) mem[addr] = dq;
	assign q_oe = wr_n & ~sel_n & sel_h & ~g_n & ~desel;
	assign q = mem[addr];
	assign int_lo = low;
	always @(posedge low) #DESEL_NS desel = 1'b1;
	always @(negedge low) #REC_NS desel = 1'b0;
endmodule

//--- verification/bsw_host_tb_top.sv
// self-checking bench for the sram bus master
// assumes bsw_sram_model on the far side of the pins
module bsw_host_tb_top;
	timeunit 1ns;
	timeprecision 1ns;
	import bsw_pkg::*;
	logic              clk = 1'b0, rst = 1'b1, req = 1'b0;
	logic              rw = 1'b0, low = 1'b0, ce = 1'b1;
	logic [ADDR_W-1:0] ra = '0, a, a0;
	logic [DATA_W-1:0] rwd = '0, rd, dqo, dqi, mq, bus_d, last, d0;
	logic              busy, done, pf, sn, sh, wn, gn, oe, moe, ilo;
	logic [31:0]       lfsr = 32'h00016b6a;
	logic [7:0]        exp_m [2**ADDR_W];
	int                err_count = 0, tests_run = 0, cyc = 0, i;
	bsw_host #(.REC_CYCLES(8)) dut_u (.clk(clk), .rst(rst), .ce(ce),
		.req(req), .req_write(rw), .req_addr(ra), .req_wdata(rwd),
		.busy(busy), .done(done), .rdata(rd), .power_fail(pf),
		.addr(a), .select_low_active_n(sn), .select_high_active(sh),
		.write_n(wn), .gate_n(gn), .dq_o(dqo), .dq_oe(oe), .dq_i(dqi),
		.pfail_int_n(~ilo));
	bsw_sram_model mem_u (.addr(a), .sel_n(sn), .sel_h(sh), .wr_n(wn),
		.g_n(gn), .dq(dqi), .low(low), .q(mq), .q_oe(moe), .int_lo(ilo));
	// released bus shows the inverse of its last value
	assign bus_d = oe ? dqo : mq;
	always @(bus_d or oe or moe) if (oe | moe) last = bus_d;
	assign dqi = (oe | moe) ? bus_d : ~last;
	initial forever #20 clk = ~clk;
	// ==========================================
	// helpers
	function automatic logic [31:0] nxt(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	task automatic chk(input string n, input logic [15:0] e, g);
		tests_run++;
		if (g !== e) begin
			err_count++;
			$display("FAIL %s expected %h seen %h", n, e, g);
		end
	endtask
	task automatic acc(input logic w, input logic [ADDR_W-1:0] ad,
		input logic [7:0] d);
		int n;
		@(posedge clk);
		req <= 1'b1;
		rw <= w;
		ra <= ad;
		rwd <= d;
		@(posedge clk);
		// hold request until taken, a frozen edge takes nothing
		for (n = 0; n < 20 && busy !== 1'b1; n++) @(posedge clk);
		req <= 1'b0;
		for (n = 0; n < 20 && done !== 1'b1; n++) begin
			@(negedge clk);
			if (w && busy === 1'b1) chk("gate", 16'h1, 16'(gn));
			if (wn === 1'b0) chk("addr", 16'(ad), 16'(a));
		end
		chk("done", 16'h1, 16'(done));
		if (!w) chk("rdata", 16'(exp_m[ad]), 16'(rd));
	endtask
	task automatic wr_rd(input logic [ADDR_W-1:0] ad, input logic [7:0] d);
		exp_m[ad] = d;
		acc(1'b1, ad, d);
		acc(1'b0, ad, d);
	endtask
	task automatic final_report;
		$display("comparisons %0d mismatches %0d", tests_run, err_count);
		if (err_count == 0 && tests_run > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	always @(posedge clk) begin
		cyc++;
		// one frozen cycle in every 61 exercises the clock enable
		ce <= (cyc % 61) != 30;
		if (cyc == 5000) begin
			err_count++;
			final_report;
		end
	end
	// ==========================================
	// main sequence
	initial begin
		repeat (2) @(posedge clk);
		rst <= 1'b0;
		wr_rd(13'h0000, 8'h00);
		wr_rd(13'h1fff, 8'hff);
		for (i = 0; i < 24; i++) begin
			lfsr = nxt(lfsr);
			a0 = lfsr[12:0];
			d0 = lfsr[20:13];
			wr_rd(a0, d0);
		end
		acc(1'b0, 13'h0000, 8'h00);
		wr_rd(13'h0aaa, 8'h5a);
		@(posedge clk);
		low <= 1'b1;
		acc(1'b1, 13'h0555, 8'ha5);
		for (i = 0; i < 10 && pf !== 1'b1; i++) @(negedge clk);
		chk("pf_set", 16'h1, 16'(pf));
		@(posedge clk);
		req <= 1'b1;
		repeat (3) @(negedge clk);
		chk("refused", 16'h0, 16'(busy));
		@(posedge clk);
		req <= 1'b0;
		repeat (400) @(posedge clk);
		low <= 1'b0;
		repeat (6) @(negedge clk);
		chk("pf_hold", 16'h1, 16'(pf));
		for (i = 0; i < 20 && pf !== 1'b0; i++) @(negedge clk);
		chk("pf_clr", 16'h0, 16'(pf));
		acc(1'b0, 13'h0aaa, 8'h00);
		wr_rd(13'h0aaa, 8'hc3);
		final_report;
	end
endmodule
